// ### core/stc_defines.svh
// Constants shared by the source transfer controller files
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH

// Clock period and stabilization interval, in ns
`define STC_CLK_NS 10
`define STC_STAB_NS 1000

// Register port widths
`define STC_AW 4
`define STC_DW 16

// Register word offsets
`define STC_ADDR_CTRL 4'h0
`define STC_ADDR_STAB 4'h1
`define STC_ADDR_STAT 4'h2

// Control register layout and reset value
`define STC_CW 9
`define STC_CTRL_RST 9'h011
`define STC_C_AUTO 0
`define STC_C_MALT 1
`define STC_C_FREQ 2
`define STC_C_PHASE 3
`define STC_C_RET 4
`define STC_C_PREF 5
`define STC_C_PSEEK 6
`define STC_C_FULL 7
`define STC_C_SIL 8
`define STC_C_CLR 9

`endif

// ### core/stc_pkg.sv
// Types shared by the source transfer controller files
`include "stc_defines.svh"

package stc_pkg;
    // Which source feeds the load
    typedef enum logic [2:0] {
        LD_OFF  = 3'b001,
        LD_NORM = 3'b010,
        LD_ALT  = 3'b100
    } load_e;
    // Stored control bits
    typedef logic [`STC_CW-1:0] ctrl_t;
endpackage

// ### core/source_qualify.sv
// Availability judgement of one source with over-frequency hysteresis
`timescale 1ns/10ps
`default_nettype none

module source_qualify #(
    parameter int NPH = 3
) (
    // Clock and control
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Configuration
    input wire logic freq_en_i,
    input wire logic full_phase_i,
    // Sensing flags
    input wire logic [NPH-1:0] pickup_i,
    input wire logic sw_open_i,
    input wire logic over_freq_i,
    input wire logic of_pickup_i,
    input wire logic under_freq_i,
    // Results
    output logic avail_o,
    output logic of_trip_o
);
    typedef struct packed {
        logic of_trip;
    } state_s;
    state_s st_ff;
    state_s nxt_st;
    logic ph_ok;
    logic freq_ok;

    assign ph_ok = full_phase_i ? (&pickup_i) : pickup_i[0];
    assign freq_ok = !freq_en_i ||
        !(st_ff.of_trip || over_freq_i || under_freq_i);
    assign avail_o = ph_ok && !sw_open_i && freq_ok;
    assign of_trip_o = st_ff.of_trip;

    // Over-frequency trip latch, released below the pickup threshold
    always_comb begin
        nxt_st = st_ff;
        if (!freq_en_i) begin
            nxt_st.of_trip = 1'b0;
        end else if (over_freq_i) begin
            nxt_st.of_trip = 1'b1;
        end else if (of_pickup_i) begin
            nxt_st.of_trip = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    over_freq_a: assert property (
        freq_en_i && over_freq_i |-> !avail_o)
        else $error("over-frequency source seen as available");
    of_hyst_a: assert property (
        ce_i && freq_en_i && st_ff.of_trip && !of_pickup_i
        |=> st_ff.of_trip && !avail_o)
        else $error("over-frequency trip released above pickup");
    under_freq_a: assert property (
        freq_en_i && under_freq_i |-> !avail_o)
        else $error("under-frequency source seen as available");
endmodule // source_qualify

`default_nettype wire

// ### core/stab_timer.sv
// Counts how long a source has continuously been available
`timescale 1ns/10ps
`default_nettype none

module stab_timer #(
    parameter int W = 16
) (
    // Clock and control
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Qualifying level and interval in cycles
    input wire logic qual_i,
    input wire logic [W-1:0] limit_i,
    // Interval elapsed
    output logic done_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } state_s;
    state_s st_ff;
    state_s nxt_st;

    assign done_o = qual_i && (st_ff.cnt >= limit_i);

    // Count while qualified, restart on any drop
    always_comb begin
        nxt_st = st_ff;
        if (!qual_i) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt < limit_i) begin
            nxt_st.cnt = st_ff.cnt + W'(1);
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    stab_wait_a: assert property (
        $past(ce_i) && $rose(qual_i) && limit_i != '0 |-> !done_o)
        else $error("stabilization reported without any wait");
endmodule // stab_timer

`default_nettype wire

// ### core/source_transfer_control.sv
// Two-source transfer switch decision logic with register port
// Functional notes
// - available needs pickup, closed switches, frequency
// - over-frequency makes source unavailable at once
// - over-frequency clears only below pickup threshold
// - under-frequency makes source unavailable
// - in-phase drop transfers if other available
// - phase feature gates in-phase transfer on mismatch
// - phase feature off ignores mismatch entirely
// - random-transfer level transfers regardless of phase
// - random level plus overload inhibits transfers
// - shorted switch selects its source, blocks transfers
// - normal seeking prefers normal source
// - power seeking keeps first available source; here it returns to the preferred source when re-transfer is on
// - re-transfer returns to preferred when available
// - re-transfer off never returns automatically
// - preferred source selectable and indicated
// - re-transfer waits stabilization interval
// - full phase protection watches every phase
// - no deliberate delay before switching
// - status, fault and alarm indications driven
// - re-transfer enabled indicator
// - manual mode holds operator-selected source
// - per-source availability indicator
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "stc_defines.svh"

module source_transfer_control
    import stc_pkg::*;
#(
    parameter int NPH = 3,
    parameter int STAB_W = 16,
    parameter int STAB_NS = `STC_STAB_NS
) (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [`STC_AW-1:0] addr_i,
    input wire logic [`STC_DW-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [`STC_DW-1:0] rdata_o,
    // Per-phase pickup flags, normal and alternate
    input wire logic [NPH-1:0] pickup_n_i,
    input wire logic [NPH-1:0] pickup_a_i,
    // Per-source flags, bit 0 normal, bit 1 alternate
    input wire logic [1:0] sw_open_i,
    input wire logic [1:0] sw_short_i,
    input wire logic [1:0] over_freq_i,
    input wire logic [1:0] of_pickup_i,
    input wire logic [1:0] under_freq_i,
    input wire logic [1:0] inphase_low_i,
    input wire logic [1:0] random_low_i,
    // Load and phase flags
    input wire logic overload_i,
    input wire logic phase_in_lim_i,
    // Switch commands
    output logic close_norm_o,
    output logic close_alt_o,
    // Indicators
    output logic [1:0] avail_o,
    output logic load_power_o,
    output logic auto_ind_o,
    output logic fault_ind_o,
    output logic pref_alt_o,
    output logic retran_en_o,
    output logic alarm_vis_o,
    output logic alarm_aud_o
);
    localparam logic [STAB_W-1:0] STAB_CYC =
        STAB_W'((STAB_NS + `STC_CLK_NS - 1) / `STC_CLK_NS);

    typedef struct packed {
        load_e ld;
        ctrl_t ctrl;
        logic [STAB_W-1:0] stab;
        logic inh_short;
        logic load_fault;
        logic cl_n;
        logic cl_a;
        logic [1:0] av;
        logic load_pwr;
        logic fault_ind;
        logic alarm_v;
        logic alarm_a;
        logic [`STC_DW-1:0] rdata;
    } state_s;

    state_s st_ff;
    state_s nxt_st;
    logic [1:0] q_av;
    logic [1:0] of_trip;
    logic [1:0] av;
    logic [2*NPH-1:0] pickup_all;
    logic act;
    logic on_src;
    logic rnd;
    logic short_any;
    logic inh_now;
    logic ph_ok;
    logic tgt;
    logic stab_done;
    logic xfer;
    logic back;
    logic clr;

    assign pickup_all = {pickup_a_i, pickup_n_i};

    for (genvar s = 0; s < 2; s++) begin : g_src
        source_qualify #(
            .NPH(NPH)
        ) u_qual (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .freq_en_i(st_ff.ctrl[`STC_C_FREQ]),
            .full_phase_i(st_ff.ctrl[`STC_C_FULL]),
            .pickup_i(pickup_all[s*NPH +: NPH]),
            .sw_open_i(sw_open_i[s]),
            .over_freq_i(over_freq_i[s]),
            .of_pickup_i(of_pickup_i[s]),
            .under_freq_i(under_freq_i[s]),
            .avail_o(q_av[s]),
            .of_trip_o(of_trip[s])
        );
    end

    assign av = q_av & ~inphase_low_i;
    assign act = (st_ff.ld == LD_ALT);
    assign on_src = (st_ff.ld != LD_OFF);
    // random-transfer level on the active source
    assign rnd = on_src && random_low_i[act];
    assign short_any = |sw_short_i;
    // load fault inhibits on this very cycle
    assign inh_now = st_ff.inh_short || st_ff.load_fault ||
        (rnd && overload_i);
    // phase gate only when feature is on
    assign ph_ok = !st_ff.ctrl[`STC_C_PHASE] || phase_in_lim_i;
    assign tgt = st_ff.ctrl[`STC_C_PSEEK] && st_ff.ctrl[`STC_C_PREF];
    assign clr = we_i && (addr_i == `STC_ADDR_CTRL) &&
        wdata_i[`STC_C_CLR];

    // stabilization only counts with re-transfer on
    stab_timer #(
        .W(STAB_W)
    ) u_stab (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .qual_i(st_ff.ctrl[`STC_C_RET] && av[tgt]),
        .limit_i(st_ff.stab),
        .done_o(stab_done)
    );

    // transfer away from a failing source
    assign xfer = (!av[act] || rnd) && av[!act] && (rnd || ph_ok);
    assign back = st_ff.ctrl[`STC_C_RET] && (act != tgt) &&
        av[tgt] && stab_done && ph_ok;

    // Next-state logic: registers, faults, source choice, indicators
    always_comb begin
        nxt_st = st_ff;
        // Register writes
        if (we_i && addr_i == `STC_ADDR_CTRL) begin
            nxt_st.ctrl = wdata_i[`STC_CW-1:0];
        end
        if (we_i && addr_i == `STC_ADDR_STAB) begin
            nxt_st.stab = wdata_i[STAB_W-1:0];
        end
        // shorted switch latch, set wins over clear
        if (short_any) begin
            nxt_st.inh_short = 1'b1;
        end else if (clr) begin
            nxt_st.inh_short = 1'b0;
        end
        // load fault latch, set wins over clear
        if (rnd && overload_i) begin
            nxt_st.load_fault = 1'b1;
        end else if (clr) begin
            nxt_st.load_fault = 1'b0;
        end
        if (sw_short_i[0]) begin
            nxt_st.ld = LD_NORM;
        end else if (sw_short_i[1]) begin
            nxt_st.ld = LD_ALT;
        end else if (inh_now) begin
            nxt_st.ld = st_ff.ld;
        end else if (!st_ff.ctrl[`STC_C_AUTO]) begin
            nxt_st.ld = st_ff.ctrl[`STC_C_MALT] ? LD_ALT : LD_NORM;
        end else begin
            // decision taken in the same cycle
            unique case (st_ff.ld)
                LD_OFF: begin
                    if (av[0]) begin
                        nxt_st.ld = LD_NORM;
                    end else if (av[1]) begin
                        nxt_st.ld = LD_ALT;
                    end
                end
                LD_NORM, LD_ALT: begin
                    if (xfer) begin
                        nxt_st.ld = act ? LD_NORM : LD_ALT;
                    end else if (back) begin
                        nxt_st.ld = tgt ? LD_ALT : LD_NORM;
                    end
                end
            endcase
        end
        nxt_st.cl_n = (nxt_st.ld == LD_NORM);
        nxt_st.cl_a = (nxt_st.ld == LD_ALT);
        nxt_st.av = av;
        nxt_st.load_pwr = (nxt_st.cl_n && av[0]) ||
            (nxt_st.cl_a && av[1]);
        nxt_st.fault_ind = nxt_st.inh_short || nxt_st.load_fault;
        nxt_st.alarm_v = nxt_st.fault_ind || !(|av);
        nxt_st.alarm_a = nxt_st.alarm_v && !nxt_st.ctrl[`STC_C_SIL];
        // Read data stands for one cycle only
        nxt_st.rdata = '0;
        if (re_i) begin
            unique case (addr_i)
                `STC_ADDR_CTRL: begin
                    nxt_st.rdata = `STC_DW'(st_ff.ctrl);
                end
                `STC_ADDR_STAB: begin
                    nxt_st.rdata = `STC_DW'(st_ff.stab);
                end
                `STC_ADDR_STAT: begin
                    nxt_st.rdata = `STC_DW'({of_trip, stab_done,
                        st_ff.load_fault, st_ff.inh_short,
                        st_ff.av, st_ff.cl_a, st_ff.cl_n});
                end
                default: begin
                    nxt_st.rdata = '0;
                end
            endcase
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.ld <= LD_OFF;
            st_ff.ctrl <= `STC_CTRL_RST;
            st_ff.stab <= STAB_CYC;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign rdata_o = st_ff.rdata;
    assign close_norm_o = st_ff.cl_n;
    assign close_alt_o = st_ff.cl_a;
    assign avail_o = st_ff.av;
    assign load_power_o = st_ff.load_pwr;
    assign fault_ind_o = st_ff.fault_ind;
    assign alarm_vis_o = st_ff.alarm_v;
    assign alarm_aud_o = st_ff.alarm_a;
    assign auto_ind_o = st_ff.ctrl[`STC_C_AUTO];
    assign pref_alt_o = st_ff.ctrl[`STC_C_PREF];
    assign retran_en_o = st_ff.ctrl[`STC_C_RET];

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence ctrl_write_s;
        ce_i && we_i && addr_i == `STC_ADDR_CTRL;
    endsequence

    sequence quiet_auto_s;
        ce_i && !we_i && !short_any && !inh_now &&
        st_ff.ctrl[`STC_C_AUTO];
    endsequence

    sequence back_ready_s;
        quiet_auto_s ##0 (st_ff.ctrl[`STC_C_RET] && on_src && act != tgt &&
        stab_done && ph_ok && av[act] && !rnd);
    endsequence

    short_sel_a: assert property (
        ce_i && short_any |=> fault_ind_o &&
        close_norm_o == $past(sw_short_i[0]) &&
        close_alt_o == !$past(sw_short_i[0]))
        else $error("shorted source not selected");
    short_block_a: assert property (
        st_ff.inh_short && !short_any && !we_i |=> $stable(st_ff.ld))
        else $error("transfer while shorted switch latched");
    load_fault_a: assert property (
        ce_i && rnd && overload_i && !short_any
        |=> fault_ind_o ##0 $stable(st_ff.ld))
        else $error("load fault not flagged or transfer made");
    manual_sel_a: assert property (
        ce_i && !we_i && !short_any && !inh_now &&
        !st_ff.ctrl[`STC_C_AUTO]
        |=> st_ff.ld == (st_ff.ctrl[`STC_C_MALT] ? LD_ALT : LD_NORM))
        else $error("manual selection not followed");
    instant_xfer_a: assert property (
        quiet_auto_s ##0 (st_ff.ld == LD_NORM && inphase_low_i[0] &&
        av[1] && !st_ff.ctrl[`STC_C_PHASE]) |=> close_alt_o)
        else $error("in-phase transfer delayed or missed");
    phase_hold_a: assert property (
        quiet_auto_s ##0 (st_ff.ld == LD_NORM && !rnd &&
        st_ff.ctrl[`STC_C_PHASE] && !phase_in_lim_i) |=> close_norm_o)
        else $error("transfer despite phase mismatch");
    retran_off_a: assert property (
        quiet_auto_s ##0 (st_ff.ld == LD_ALT && av[1] && !rnd &&
        !st_ff.ctrl[`STC_C_RET]) |=> close_alt_o [*1])
        else $error("automatic return with re-transfer off");
    ind_follow_a: assert property (
        ctrl_write_s |=> retran_en_o == $past(wdata_i[`STC_C_RET]) &&
        pref_alt_o == $past(wdata_i[`STC_C_PREF]))
        else $error("indicator does not follow control write");
    avail_ind_a: assert property (
        ce_i |=> avail_o == $past(av))
        else $error("availability indicator wrong");
    retran_back_a: assert property (
        back_ready_s |=> close_alt_o == $past(tgt))
        else $error("re-transfer to target source missed");
    random_xfer_a: assert property (
        quiet_auto_s ##0 (rnd && !overload_i && av[!act])
        |=> close_alt_o == !$past(act))
        else $error("random-transfer level did not move the load");
    off_pick_a: assert property (
        quiet_auto_s ##0 (st_ff.ld == LD_OFF && av[0]) |=> close_norm_o)
        else $error("load off did not pick the normal source");
endmodule // source_transfer_control

`default_nettype wire

// ### sim/sense_front_end.sv
// Sensing front end model: coded source conditions become flags
`timescale 1ns/10ps
`default_nettype none

module sense_front_end (
    // Clock
    input wire logic clock_i,
    // Codes, two bits a source, normal in 1:0, then single overload and phase bits
    input wire logic [3:0] volt_i,
    input wire logic [3:0] freq_i,
    input wire logic ovl_i,
    input wire logic phok_i,
    // Flags toward the controller
    output logic [2:0] pickup_n_o,
    output logic [2:0] pickup_a_o,
    output logic [1:0] over_freq_o,
    output logic [1:0] of_pickup_o,
    output logic [1:0] under_freq_o,
    output logic [1:0] inphase_low_o,
    output logic [1:0] random_low_o,
    output logic overload_o,
    output logic phase_in_lim_o
);
    // Volt code 0 good, 1 sagging, 2 collapsed, 3 last phase lost
    function automatic logic [2:0] pick(input logic [1:0] v);
        return (v < 2'h2) ? 3'h7 : ((v == 2'h3) ? 3'h3 : 3'h0);
    endfunction

    always_ff @(posedge clock_i) begin
        pickup_n_o <= pick(volt_i[1:0]);
        pickup_a_o <= pick(volt_i[3:2]);
        for (int s = 0; s < 2; s++) begin
            inphase_low_o[s] <= volt_i[2*s+:2] inside {2'h1, 2'h2};
            random_low_o[s] <= (volt_i[2*s+:2] == 2'h2);
            over_freq_o[s] <= (freq_i[2*s+:2] == 2'h1);
            of_pickup_o[s] <= (freq_i[2*s+:2] inside {2'h0, 2'h3});
            under_freq_o[s] <= (freq_i[2*s+:2] == 2'h3);
        end
        overload_o <= ovl_i;
        phase_in_lim_o <= phok_i;
    end
endmodule // sense_front_end
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the source transfer controller
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic ce = 1'b1;
    logic ovl = 1'b0;
    logic phok = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [3:0] volt = 4'h0;
    logic [3:0] freq = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic [1:0] sw_open_i = 2'b00;
    logic [1:0] sw_short_i = 2'b00;
    logic [15:0] rdata_o;
    logic [2:0] pickup_n_i, pickup_a_i;
    logic [1:0] over_freq_i, of_pickup_i, under_freq_i, avail_o, sel;
    logic [1:0] inphase_low_i, random_low_i;
    logic overload_i, phase_in_lim_i, close_norm_o, close_alt_o;
    logic load_power_o, auto_ind_o, fault_ind_o, pref_alt_o;
    logic retran_en_o, alarm_vis_o, alarm_aud_o;
    int mismatches = 0;
    int comparisons = 0;

    // Switch selection as one field, alternate in bit 1
    assign sel = {close_alt_o, close_norm_o};

    sense_front_end sense_front_end_inst (.clock_i, .volt_i(volt),
        .freq_i(freq), .ovl_i(ovl), .phok_i(phok),
        .pickup_n_o(pickup_n_i), .pickup_a_o(pickup_a_i),
        .over_freq_o(over_freq_i), .of_pickup_o(of_pickup_i),
        .under_freq_o(under_freq_i), .inphase_low_o(inphase_low_i),
        .random_low_o(random_low_i), .overload_o(overload_i),
        .phase_in_lim_o(phase_in_lim_i));

    source_transfer_control source_transfer_control_inst (.clock_i,
        .rst_i, .ce_i(ce), .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
        .pickup_n_i, .pickup_a_i, .sw_open_i, .sw_short_i, .over_freq_i,
        .of_pickup_i, .under_freq_i, .inphase_low_i, .random_low_i,
        .overload_i, .phase_in_lim_i, .close_norm_o, .close_alt_o,
        .avail_o, .load_power_o, .auto_ind_o, .fault_ind_o, .pref_alt_o,
        .retran_en_o, .alarm_vis_o, .alarm_aud_o);

    // Free-running 100 MHz clock
    initial begin
        forever #5 clock_i = ~clock_i;
    end

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clock_i);
        we_i <= 1'b0;
        #1;
    endtask

    task automatic rd(logic [3:0] a, logic [15:0] e, string n);
        @(posedge clock_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clock_i);
        re_i <= 1'b0;
        #1;
        chk(n, e, rdata_o);
    endtask

    // Front end reacts one edge later, the controller one more
    task automatic set(logic [3:0] v, logic [3:0] f, logic o, logic p);
        @(posedge clock_i);
        volt <= v;
        freq <= f;
        ovl <= o;
        phok <= p;
        tick(2);
    endtask

    task automatic init(logic [3:0] v);
        @(posedge clock_i);
        rst_i <= 1'b1;
        sw_open_i <= 2'b00;
        sw_short_i <= 2'b00;
        volt <= v;
        freq <= 4'h0;
        ovl <= 1'b0;
        phok <= 1'b1;
        @(posedge clock_i);
        rst_i <= 1'b0;
        tick(2);
    endtask

    task automatic t_regs;
        init(4'h0);
        rd(4'h0, 16'h0011, "ctrl");
        rd(4'h1, 16'h0064, "stab");
        rd(4'h7, 16'h0000, "unmapped");
        rd(4'h2, 16'h000d, "status");
        chk("ind", 3'b110, {auto_ind_o, retran_en_o, pref_alt_o});
        chk("avail", 2'b11, avail_o);
        chk("power", 1'b1, load_power_o);
        chk("sel", 2'b01, sel);
        wr(4'h0, 16'h0021);
        chk("ind", 3'b101, {auto_ind_o, retran_en_o, pref_alt_o});
        // Clock enable low must swallow a write
        @(posedge clock_i);
        ce <= 1'b0;
        wr(4'h0, 16'h0001);
        chk("frozen", 3'b101, {auto_ind_o, retran_en_o, pref_alt_o});
        @(posedge clock_i);
        ce <= 1'b1;
        $display("regs done");
    endtask

    task automatic t_phase;
        init(4'h0);
        wr(4'h0, 16'h0019);
        set(4'h1, 4'h0, 1'b0, 1'b0);
        chk("sel", 2'b01, sel);
        chk("avail", 2'b10, avail_o);
        set(4'h1, 4'h0, 1'b0, 1'b1);
        chk("sel", 2'b10, sel);
        init(4'h0);
        set(4'h9, 4'h0, 1'b0, 1'b0);
        chk("alt", 1'b0, close_alt_o);
        set(4'h1, 4'h0, 1'b0, 1'b0);
        chk("sel", 2'b10, sel);
        $display("phase done");
    endtask

    task automatic t_random;
        init(4'h0);
        wr(4'h0, 16'h0019);
        set(4'h2, 4'h0, 1'b0, 1'b0);
        chk("sel", 2'b10, sel);
        init(4'h0);
        set(4'h2, 4'h0, 1'b1, 1'b1);
        chk("sel", 2'b01, sel);
        chk("fault", 1'b1, fault_ind_o);
        chk("alarm", 2'b11, {alarm_vis_o, alarm_aud_o});
        wr(4'h0, 16'h0111);
        tick(1);
        chk("alarm", 2'b10, {alarm_vis_o, alarm_aud_o});
        $display("random done");
    endtask

    task automatic t_freq;
        init(4'h0);
        wr(4'h0, 16'h0015);
        set(4'h0, 4'h4, 1'b0, 1'b1);
        chk("avail", 2'b01, avail_o);
        set(4'h0, 4'h8, 1'b0, 1'b1);
        chk("avail", 2'b01, avail_o);
        set(4'h0, 4'h0, 1'b0, 1'b1);
        // Trip latch releases one edge after the pickup flag
        tick(1);
        chk("avail", 2'b11, avail_o);
        set(4'h0, 4'hc, 1'b0, 1'b1);
        chk("avail", 2'b01, avail_o);
        wr(4'h0, 16'h0011);
        set(4'h0, 4'h4, 1'b0, 1'b1);
        chk("avail", 2'b11, avail_o);
        @(posedge clock_i);
        sw_open_i <= 2'b10;
        tick(2);
        chk("avail", 2'b01, avail_o);
        $display("freq done");
    endtask

    task automatic t_retran;
        init(4'h0);
        wr(4'h1, 16'h0002);
        set(4'h2, 4'h0, 1'b0, 1'b1);
        chk("sel", 2'b10, sel);
        set(4'h0, 4'h0, 1'b0, 1'b1);
        chk("sel", 2'b10, sel);
        tick(1);
        chk("sel", 2'b10, sel);
        tick(1);
        chk("sel", 2'b01, sel);
        wr(4'h0, 16'h0001);
        set(4'h2, 4'h0, 1'b0, 1'b1);
        set(4'h0, 4'h0, 1'b0, 1'b1);
        tick(10);
        chk("sel", 2'b10, sel);
        // Power seeking with alternate preferred and re-transfer on
        wr(4'h0, 16'h0071);
        set(4'h8, 4'h0, 1'b0, 1'b1);
        chk("sel", 2'b01, sel);
        set(4'h0, 4'h0, 1'b0, 1'b1);
        tick(2);
        chk("sel", 2'b10, sel);
        $display("retransfer done");
    endtask

    task automatic t_short;
        init(4'h0);
        @(posedge clock_i);
        sw_short_i <= 2'b10;
        tick(2);
        chk("sel", 2'b10, sel);
        chk("fault", 1'b1, fault_ind_o);
        set(4'h8, 4'h0, 1'b0, 1'b1);
        chk("sel", 2'b10, sel);
        @(posedge clock_i);
        sw_short_i <= 2'b00;
        wr(4'h0, 16'h0211);
        tick(2);
        chk("sel", 2'b01, sel);
        $display("short done");
    endtask

    task automatic t_modes;
        init(4'h0);
        wr(4'h0, 16'h0012);
        set(4'h8, 4'h0, 1'b0, 1'b1);
        chk("sel", 2'b10, sel);
        chk("auto", 1'b0, auto_ind_o);
        init(4'h2);
        wr(4'h0, 16'h0041);
        set(4'h0, 4'h0, 1'b0, 1'b1);
        tick(5);
        chk("sel", 2'b10, sel);
        set(4'h4, 4'h0, 1'b0, 1'b1);
        chk("sel", 2'b01, sel);
        init(4'h0);
        set(4'h3, 4'h0, 1'b0, 1'b1);
        chk("sel", 2'b01, sel);
        wr(4'h0, 16'h0091);
        tick(1);
        chk("sel", 2'b10, sel);
        $display("modes done");
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        t_regs;
        t_phase;
        t_random;
        t_freq;
        t_retran;
        t_short;
        t_modes;
        summarize;
    end

    // Watchdog well beyond the expected run
    initial begin
        #50000;
        mismatches++;
        summarize;
    end
endmodule // testbench
`default_nettype wire
